// ===== bench/testbench.sv
// self-checking bench for the frame time-stamp counters
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_n_in = 0, timestamp_counter_enable_in = 0;
  logic frame_stamp_enable_in = 0, time_capture_input_in = 0;
  logic [1:0] stamp_format_in = 2'h0;
  logic [2:0] cmd = 3'h0;
  logic [31:0] one_second_compare_value_in = 32'h28, f0, n0;
  logic rx_frame_start_in, tx_frame_start_in, tx_stamp_request_in;
  logic [31:0] freerun_count_out, freerun_capture_value_out, seconds_out;
  logic [31:0] nanoseconds_out, rx_stamp_seconds_out, rx_stamp_low_out;
  logic [31:0] tx_stamp_seconds_out, tx_stamp_low_out;
  logic freerun_capture_valid_out, rx_stamp_valid_out, tx_stamp_valid_out;
  int errors = 0, total_checks = 0;
  frame_timestamp_counters dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .timestamp_counter_enable_in(timestamp_counter_enable_in),
    .frame_stamp_enable_in(frame_stamp_enable_in),
    .stamp_format_in(stamp_format_in),
    .one_second_compare_value_in(one_second_compare_value_in),
    .time_capture_input_in(time_capture_input_in),
    .rx_frame_start_in(rx_frame_start_in),
    .tx_frame_start_in(tx_frame_start_in),
    .tx_stamp_request_in(tx_stamp_request_in),
    .freerun_count_out(freerun_count_out),
    .freerun_capture_value_out(freerun_capture_value_out),
    .freerun_capture_valid_out(freerun_capture_valid_out),
    .seconds_out(seconds_out),
    .nanoseconds_out(nanoseconds_out),
    .rx_stamp_seconds_out(rx_stamp_seconds_out),
    .rx_stamp_low_out(rx_stamp_low_out),
    .rx_stamp_valid_out(rx_stamp_valid_out),
    .tx_stamp_seconds_out(tx_stamp_seconds_out),
    .tx_stamp_low_out(tx_stamp_low_out),
    .tx_stamp_valid_out(tx_stamp_valid_out)
  );
  ts_partner partner (.clk_in, .rst_n_in, .cmd_in(cmd), .start_out(
    {tx_stamp_request_in, tx_frame_start_in, rx_frame_start_in}));
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(string name, logic [31:0] exp, got);
    total_checks++;
    if (exp !== got)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // frame via partner; settle past the taking edge before judging
  task automatic frame(logic [2:0] c, logic [1:0] f, logic erx, etx);
    @(posedge clk_in);
    cmd <= c;
    stamp_format_in <= f;
    @(posedge clk_in);
    cmd <= 3'h0;
    tick(1);
    chk("rx valid", erx, rx_stamp_valid_out);
    chk("tx valid", etx, tx_stamp_valid_out);
    if (erx && !f[0])
      chk("rx seconds", 0, rx_stamp_seconds_out);
  endtask
  task automatic results;
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // wrap at 40 ns: ten steps of 4 ns from zero
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1;
    @(posedge clk_in);
    timestamp_counter_enable_in <= 1;
    tick(10);
    chk("ns", 0, nanoseconds_out);
    chk("seconds", 1, seconds_out);
    f0 = freerun_count_out;
    tick(250);
    chk("freerun", 120, freerun_count_out - f0);
    @(posedge clk_in);
    timestamp_counter_enable_in <= 0;
    tick(1);
    f0 = freerun_count_out;
    n0 = nanoseconds_out;
    tick(20);
    chk("freerun hold", f0, freerun_count_out);
    chk("ns hold", n0, nanoseconds_out);
    @(posedge clk_in);
    timestamp_counter_enable_in <= 1;
    frame(3'h1, 2'h0, 0, 0);
    @(posedge clk_in);
    frame_stamp_enable_in <= 1;
    for (int f = 0; f < 4; f++)
      frame(3'h1, f[1:0], 1, 0);
    frame(3'h2, 2'h1, 0, 0);
    frame(3'h7, 2'h2, 1, 1);
    @(posedge clk_in);
    time_capture_input_in <= 1;
    tick(1);
    chk("capture valid", 1, freerun_capture_valid_out);
    results;
  end
endmodule

// ===== bench/ts_checker_assertions.sv
// port assertions for the frame time-stamp counters
module ts_checker (
  input wire clk_in, rst_n_in, timestamp_counter_enable_in,
  input wire frame_stamp_enable_in, rx_frame_start_in, tx_frame_start_in,
  input wire tx_stamp_request_in, time_capture_input_in,
  input wire [1:0] stamp_format_in,
  input wire [31:0] one_second_compare_value_in, nanoseconds_out,
  input wire [31:0] seconds_out, freerun_count_out, rx_stamp_low_out,
  input wire [31:0] freerun_capture_value_out,
  input wire [31:0] rx_stamp_seconds_out, tx_stamp_seconds_out,
  input wire [31:0] tx_stamp_low_out,
  input wire rx_stamp_valid_out, tx_stamp_valid_out, freerun_capture_valid_out
);
  // short names for the counter state
  wire ts = timestamp_counter_enable_in;
  wire both_en = ts & frame_stamp_enable_in;
  wire [31:0] ns = nanoseconds_out;
  wire [31:0] short_now = {seconds_out[1:0], ns[29:0]};
  wire [31:0] long_now = {2'h0, ns[29:0]};
  wire wrap = ns + 32'h4 >= one_second_compare_value_in; // pre-update count
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence rx_taken;
    rx_frame_start_in && both_en;
  endsequence
  sequence tx_taken;
    tx_frame_start_in && tx_stamp_request_in && both_en;
  endsequence
  rx_stamp_a: assert property (rx_taken |=> rx_stamp_valid_out)
    else $error("rx stamp missing");
  rx_gate_a: assert property (!rx_taken |=> !rx_stamp_valid_out)
    else $error("rx stamp unasked");
  tx_gate_a: assert property (tx_frame_start_in && !tx_stamp_request_in
    |=> !tx_stamp_valid_out) else $error("tx stamp unasked");
  ns_step_a: assert property (ts && !wrap |=> ns == $past(ns) + 32'h4)
    else $error("ns step wrong");
  ns_wrap_a: assert property (ts && wrap |=> ns == 32'h0
    && seconds_out == $past(seconds_out) + 32'h1) else $error("wrap wrong");
  hold_a: assert property (!ts |=> $stable(ns)
    && $stable(freerun_count_out)) else $error("counter moved");
  capture_a: assert property ($rose(time_capture_input_in)
    |=> freerun_capture_valid_out
    && freerun_capture_value_out == $past(freerun_count_out))
    else $error("capture wrong");
  short_fmt_a: assert property (rx_taken ##0 stamp_format_in == 2'h0
    |=> rx_stamp_low_out == $past(short_now)) else $error("short stamp");
  tx_stamp_a: assert property (tx_taken |=> tx_stamp_valid_out)
    else $error("tx stamp missing");
  long_fmt_a: assert property (rx_taken ##0 stamp_format_in == 2'h1
    |=> rx_stamp_seconds_out == $past(seconds_out)
    && rx_stamp_low_out == $past(long_now)) else $error("long stamp");
  spare_code_a: assert property (rx_taken ##0 stamp_format_in == 2'h3
    |=> rx_stamp_seconds_out == $past(seconds_out)
    && rx_stamp_low_out == $past(long_now)) else $error("code 3 stamp");
  free_fmt_a: assert property (rx_taken ##0 stamp_format_in == 2'h2
    |=> rx_stamp_seconds_out == 32'h0
    && rx_stamp_low_out == $past(freerun_count_out)) else $error("free stamp");
  tx_free_a: assert property (tx_taken ##0 stamp_format_in == 2'h2
    |=> tx_stamp_seconds_out == 32'h0
    && tx_stamp_low_out == $past(freerun_count_out)) else $error("tx stamp");
endmodule
bind frame_timestamp_counters ts_checker chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .timestamp_counter_enable_in(timestamp_counter_enable_in),
  .frame_stamp_enable_in(frame_stamp_enable_in),
  .rx_frame_start_in(rx_frame_start_in),
  .tx_frame_start_in(tx_frame_start_in),
  .tx_stamp_request_in(tx_stamp_request_in),
  .time_capture_input_in(time_capture_input_in),
  .stamp_format_in(stamp_format_in),
  .one_second_compare_value_in(one_second_compare_value_in),
  .nanoseconds_out(nanoseconds_out),
  .seconds_out(seconds_out),
  .freerun_count_out(freerun_count_out),
  .rx_stamp_low_out(rx_stamp_low_out),
  .freerun_capture_value_out(freerun_capture_value_out),
  .rx_stamp_seconds_out(rx_stamp_seconds_out),
  .tx_stamp_seconds_out(tx_stamp_seconds_out),
  .tx_stamp_low_out(tx_stamp_low_out),
  .rx_stamp_valid_out(rx_stamp_valid_out),
  .tx_stamp_valid_out(tx_stamp_valid_out),
  .freerun_capture_valid_out(freerun_capture_valid_out)
);

// ===== bench/ts_partner.sv
// far-side frame source turning bench commands into frame starts
module ts_partner (
  input wire clk_in,
  input wire rst_n_in,
  input wire [2:0] cmd_in,
  output logic [2:0] start_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle starts; the stamp request only rides with a transmit start
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      start_out <= 3'h0;
    else
      start_out <= {cmd_in[2] & cmd_in[1], cmd_in[1:0]};
endmodule

// ===== logic/frame_timestamp_counters.v
// free-running and syntonized time counters with frame stamp capture
`include "frame_timestamp_defines.vh"
module frame_timestamp_counters
#(
  parameter FREE_WIDTH = `FREERUN_WIDTH
)
(
  input wire clk_in,
  input wire rst_n_in,
  input wire timestamp_counter_enable_in,
  input wire frame_stamp_enable_in,
  input wire [1:0] stamp_format_in,
  input wire [31:0] one_second_compare_value_in,
  input wire time_capture_input_in,
  input wire rx_frame_start_in,
  input wire tx_frame_start_in,
  input wire tx_stamp_request_in,
  output reg [FREE_WIDTH-1:0] freerun_count_out,
  output reg [FREE_WIDTH-1:0] freerun_capture_value_out,
  output reg freerun_capture_valid_out,
  output reg [31:0] seconds_out,
  output reg [31:0] nanoseconds_out,
  output reg [31:0] rx_stamp_seconds_out,
  output reg [31:0] rx_stamp_low_out,
  output reg rx_stamp_valid_out,
  output reg [31:0] tx_stamp_seconds_out,
  output reg [31:0] tx_stamp_low_out,
  output reg tx_stamp_valid_out
);

  // ********************
  // fractional rate generator
  // ********************
  // 120 MHz ticks derived from the 250 MHz core by phase accumulation;
  // average rate is exact, jitter is one core period
  localparam [8:0] RATE_STEP = `FREERUN_RATE_MHZ;
  localparam [8:0] RATE_MOD = `CORE_RATE_MHZ;
  localparam [31:0] NS_STEP = `CLK_PERIOD_NS;

  // accumulator and edge-detect state
  reg [8:0] phase;
  reg capture_prev;

  // next values, worked out combinationally and loaded on every edge
  reg [8:0] next_phase;
  reg [FREE_WIDTH-1:0] next_freerun_count;
  reg [FREE_WIDTH-1:0] next_capture_value;
  reg next_capture_valid;
  reg [31:0] next_seconds;
  reg [31:0] next_nanoseconds;
  reg [31:0] next_rx_stamp_seconds;
  reg [31:0] next_rx_stamp_low;
  reg next_rx_stamp_valid;
  reg [31:0] next_tx_stamp_seconds;
  reg [31:0] next_tx_stamp_low;
  reg next_tx_stamp_valid;

  // decoded strobes
  wire [8:0] phase_sum;
  wire freerun_tick;
  wire capture_edge;
  wire ns_wrap;
  wire stamps_allowed;
  wire rx_take;
  wire tx_take;

  // a 9-bit sum cannot overflow: phase stays below 250, step is 120
  assign phase_sum = phase + RATE_STEP;
  // one free-running tick per accumulator wrap, only while enabled
  assign freerun_tick = timestamp_counter_enable_in && (phase_sum >= RATE_MOD);
  // capture_prev resets low, the idle level of the capture pin, so the
  // release of reset never shows a false rising edge
  assign capture_edge = time_capture_input_in && !capture_prev;
  // compare before adding so a compare value not a multiple of 4 still wraps
  assign ns_wrap = (nanoseconds_out + NS_STEP) >= one_second_compare_value_in;
  // frame stamps need the counters running and software's frame enable
  assign stamps_allowed = timestamp_counter_enable_in && frame_stamp_enable_in;
  assign rx_take = rx_frame_start_in && stamps_allowed;
  // a transmit start without a stamp request is ignored here
  assign tx_take = tx_frame_start_in && tx_stamp_request_in &&
    stamps_allowed;

  // stamp builder shared by receive and transmit paths
  function [63:0] build_stamp;
    input [1:0] fmt;
    input [31:0] sec;
    input [31:0] ns;
    input [FREE_WIDTH-1:0] free;
    begin
      case (fmt)
        `FMT_SHORT_SECONDS:
          build_stamp = {32'h00000000, sec[`SEC_SHORT_MSB:0],
            ns[`NS_FIELD_MSB:0]};
        `FMT_LONG_SECONDS:
          build_stamp = {sec, 2'h0, ns[`NS_FIELD_MSB:0]};
        `FMT_FREERUN:
          build_stamp = {32'h00000000, free[31:0]};
        // code 3 is unassigned; it falls back to the long format
        default:
          build_stamp = {sec, 2'h0, ns[`NS_FIELD_MSB:0]};
      endcase
    end
  endfunction

  wire [63:0] live_stamp;
  assign live_stamp = build_stamp(stamp_format_in, seconds_out,
    nanoseconds_out, freerun_count_out);

  // ********************
  // free-running counter
  // ********************
  // phase only advances while enabled so restart resumes cleanly;
  // it wraps modulo 250 and each wrap is one free-running tick
  always @*
  begin
    next_phase = phase;
    if (timestamp_counter_enable_in)
    begin
      if (phase_sum >= RATE_MOD)
        next_phase = phase_sum - RATE_MOD;
      else
        next_phase = phase_sum;
    end
  end

  // accumulator register
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      phase <= 9'h000;
    else
      phase <= next_phase;
  end

  // 32 bits at 120 MHz wrap after about 35.8 s, ample for a peer delay
  // exchange; the free-running stamp format assumes the 32-bit default
  always @*
  begin
    next_freerun_count = freerun_count_out;
    if (freerun_tick)
      next_freerun_count = freerun_count_out + 1'b1;
  end

  // count register
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      freerun_count_out <= {FREE_WIDTH{1'b0}};
    else
      freerun_count_out <= next_freerun_count;
  end

  // ********************
  // external capture
  // ********************
  // the valid pulse stands one cycle, the value until the next capture;
  // an input held high captures once and must fall before the next one
  always @*
  begin
    next_capture_valid = capture_edge;
    next_capture_value = freerun_capture_value_out;
    if (capture_edge)
      next_capture_value = freerun_count_out;
  end

  // capture registers; the count is taken before this edge's increment
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      capture_prev <= 1'b0;
      freerun_capture_value_out <= {FREE_WIDTH{1'b0}};
      freerun_capture_valid_out <= 1'b0;
    end
    else
    begin
      capture_prev <= time_capture_input_in;
      freerun_capture_value_out <= next_capture_value;
      freerun_capture_valid_out <= next_capture_valid;
    end
  end

  // ********************
  // syntonized counter
  // ********************
  // nanoseconds step by one core period; wrapping on the step that would
  // reach the compare value keeps the seconds carry exact;
  // the count freezes, rather than clears, while the enable is low
  always @*
  begin
    next_seconds = seconds_out;
    next_nanoseconds = nanoseconds_out;
    if (timestamp_counter_enable_in)
    begin
      // carry into seconds at the compare value
      if (ns_wrap)
      begin
        next_nanoseconds = 32'h00000000;
        next_seconds = seconds_out + 32'h00000001;
      end
      else
        next_nanoseconds = nanoseconds_out + NS_STEP;
    end
  end

  // time registers
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seconds_out <= 32'h00000000;
      nanoseconds_out <= 32'h00000000;
    end
    else
    begin
      seconds_out <= next_seconds;
      nanoseconds_out <= next_nanoseconds;
    end
  end

  // ********************
  // frame stamp capture
  // ********************
  // every received frame while stamps are allowed, delivered ahead of its data by the frame path;
  // the stamp words hold until the next taken frame
  // rx and tx may be taken in one cycle; each keeps its own words
  always @*
  begin
    next_rx_stamp_seconds = rx_stamp_seconds_out;
    next_rx_stamp_low = rx_stamp_low_out;
    next_rx_stamp_valid = 1'b0;
    // stamp words come from the counters before this edge's update
    if (rx_take)
    begin
      next_rx_stamp_seconds = live_stamp[63:32];
      next_rx_stamp_low = live_stamp[31:0];
      next_rx_stamp_valid = 1'b1;
    end
  end

  // receive stamp registers
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_stamp_seconds_out <= 32'h00000000;
      rx_stamp_low_out <= 32'h00000000;
      rx_stamp_valid_out <= 1'b0;
    end
    else
    begin
      rx_stamp_seconds_out <= next_rx_stamp_seconds;
      rx_stamp_low_out <= next_rx_stamp_low;
      rx_stamp_valid_out <= next_rx_stamp_valid;
    end
  end

  // transmit only on request, so software times just the frames it picks;
  // a tx start with no request leaves the held words alone
  always @*
  begin
    next_tx_stamp_seconds = tx_stamp_seconds_out;
    next_tx_stamp_low = tx_stamp_low_out;
    next_tx_stamp_valid = 1'b0;
    if (tx_take)
    begin
      next_tx_stamp_seconds = live_stamp[63:32];
      next_tx_stamp_low = live_stamp[31:0];
      next_tx_stamp_valid = 1'b1;
    end
  end

  // transmit stamp registers
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_stamp_seconds_out <= 32'h00000000;
      tx_stamp_low_out <= 32'h00000000;
      tx_stamp_valid_out <= 1'b0;
    end
    else
    begin
      tx_stamp_seconds_out <= next_tx_stamp_seconds;
      tx_stamp_low_out <= next_tx_stamp_low;
      tx_stamp_valid_out <= next_tx_stamp_valid;
    end
  end

endmodule

// ===== logic/frame_timestamp_defines.vh
// constants for the frame time-stamp counters
`ifndef FRAME_TIMESTAMP_DEFINES_VH
`define FRAME_TIMESTAMP_DEFINES_VH
`define CLK_PERIOD_NS 4
`define FREERUN_RATE_MHZ 120
`define CORE_RATE_MHZ 250
`define FREERUN_WIDTH 32
`define ONE_SECOND_COMPARE_RESET 32'h3B9ACA00
`define FMT_SHORT_SECONDS 2'h0
`define FMT_LONG_SECONDS 2'h1
`define FMT_FREERUN 2'h2
`define NS_FIELD_MSB 29
`define SEC_SHORT_MSB 1
`endif
